// *** design/spu_params.svh ***
// Register indices, field positions, reset values and bit-timing counts of the serial port.
`ifndef SPU_PARAMS_SVH
`define SPU_PARAMS_SVH
`define SPU_IDX_POWER_AND_SERIAL_OPTIONS 8'h87
`define SPU_IDX_SERIAL_PORT_CONTROL 8'h98
`define SPU_IDX_DATA 8'h99
`define SPU_IDX_ADDR 8'ha9
`define SPU_IDX_ADMASK 8'hb9
`define SPU_IDX_CLKSEL 8'hc8
`define SPU_IDX_IRQ_ST 8'hf0
`define SPU_IDX_IRQ_MASK 8'hf1
`define SPU_POWER_AND_SERIAL_OPTIONS_RST 8'h10
`define SPU_SERIAL_PORT_CONTROL_RST 8'h00
`define SPU_CLKSEL_RST 8'h00
`define SPU_POWER_AND_SERIAL_OPTIONS_DOUBLER 7
`define SPU_POWER_AND_SERIAL_OPTIONS_VIEW 6
`define SPU_SERIAL_PORT_CONTROL_SM0 7
`define SPU_SERIAL_PORT_CONTROL_SM1 6
`define SPU_SERIAL_PORT_CONTROL_SM2 5
`define SPU_SERIAL_PORT_CONTROL_REN 4
`define SPU_SERIAL_PORT_CONTROL_TB8 3
`define SPU_SERIAL_PORT_CONTROL_RB8 2
`define SPU_SERIAL_PORT_CONTROL_TI 1
`define SPU_SERIAL_PORT_CONTROL_RI 0
`define SPU_CLKSEL_SIX 0
`define SPU_CLKSEL_TX 4
`define SPU_CLKSEL_RX 5
`define SPU_IRQ_RX 0
`define SPU_IRQ_TX 1
`define SPU_IRQ_FE 2
`define SPU_FIX_DIV 3'd4
`define SPU_OVS_LAST 4'd15
`define SPU_OVS_MID 4'd7
`define SPU_M0_LAST_12 4'd11
`define SPU_M0_LAST_6 4'd5
`define SPU_M0_HALF_12 4'd6
`define SPU_M0_HALF_6 4'd3
`endif

// *** design/spu_pkg.sv ***
// Types shared by the serial port and its bench.
package spu_pkg;
  typedef enum logic [1:0] {
    SPU_MODE_SHIFT = 2'b00,
    SPU_MODE_UART8 = 2'b01,
    SPU_MODE_FIXED9 = 2'b10,
    SPU_MODE_VAR9 = 2'b11
  } spu_mode_type;
  typedef enum logic [2:0] {
    SPU_IDLE = 3'b000,
    SPU_START = 3'b001,
    SPU_DATA = 3'b010,
    SPU_NINTH = 3'b011,
    SPU_STOP = 3'b100
  } spu_state_type;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } spu_wb_req_type;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } spu_wb_rsp_type;
endpackage : spu_pkg

// *** design/spu_uart.sv ***
// Serial port with four modes, address filtering, Wishbone registers and one interrupt.
// Summary of operation
// [R1] Two mode bits pick shift, 8-bit variable, 9-bit fixed or 9-bit variable.
// [R2] Shift mode bit rate is clock over 6 or over 12.
// [R3] Fixed 9-bit rate is clock over 32/16 or over 64/32.
// [R4] Control bit 7 maps mode bit or framing error by view select.
// [R5] Invalid stop bit sets framing error until software clears it.
// [R6] 9-bit filtering: receive done only for ninth bit one and address hit.
// [R7] 8-bit filtering: receive done only with a valid stop bit.
// [R8] Software keeps address filtering off in shift mode.
// [R9] Reception happens only while receive enable is one.
// [R10] 9-bit modes send the written ninth bit as ninth data bit.
// [R11] Received ninth field holds ninth bit, or stop bit in unfiltered 8-bit mode.
// [R12] Transmit done at end of eighth bit in shift mode, else at stop start.
// [R13] Receive done at end of eighth bit in shift mode, else mid stop.
// [R14] Receiver uses second timer overflow when its select bit is set.
// [R15] Transmitter uses second timer overflow when its select bit is set.
// [R16] Doubler picks faster fixed rate and doubles first timer rate.
`include "spu_params.svh"
module spu_uart (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register bus
  input wire spu_pkg::spu_wb_req_type wb_req,
  output spu_pkg::spu_wb_rsp_type wb_rsp,
  // Baud pulses from the timers
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  // Line pins
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  // Interrupt
  output logic irq
);
  import spu_pkg::*;

  logic [7:0] power_and_serial_options, clksel, addr, admask, rx_buf, irq_st, irq_mask;
  logic mode_select_hi, mode_select_lo, address_filter_enable, rx_enable;
  logic tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag, framing_error_flag;
  logic [1:0] fix_cnt;
  logic t1_half, rxd_prev;
  spu_state_type tx_state, next_tx_state, rx_state, next_rx_state;
  logic [3:0] tx_phase, rx_phase, rx_cnt;
  logic [2:0] tx_cnt;
  logic [7:0] tx_shift, rx_shift;
  logic tx_nine, rx_nine, tx_ninth_hold;

  // Bus decode; a write lands on the edge at which the master sees ack.
  wire acc = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
  wire wr = wb_req.cyc & wb_req.stb & wb_rsp.ack & wb_req.we & wb_req.sel[0];
  wire [7:0] wd = wb_req.dat[7:0];
  wire in_map = wb_req.adr[31:10] == 22'h0 && wb_req.adr[1:0] == 2'b00;
  wire [7:0] idx = wb_req.adr[9:2];
  wire hit_power_and_serial_options = in_map && idx == `SPU_IDX_POWER_AND_SERIAL_OPTIONS;
  wire hit_serial_port_control = in_map && idx == `SPU_IDX_SERIAL_PORT_CONTROL;
  wire hit_data = in_map && idx == `SPU_IDX_DATA;
  wire hit_addr = in_map && idx == `SPU_IDX_ADDR;
  wire hit_admask = in_map && idx == `SPU_IDX_ADMASK;
  wire hit_clksel = in_map && idx == `SPU_IDX_CLKSEL;
  wire hit_st = in_map && idx == `SPU_IDX_IRQ_ST;
  wire hit_mask = in_map && idx == `SPU_IDX_IRQ_MASK;
  wire wr_serial_port_control = wr && hit_serial_port_control;

  wire baud_doubler = power_and_serial_options[`SPU_POWER_AND_SERIAL_OPTIONS_DOUBLER];
  wire framing_view_select = power_and_serial_options[`SPU_POWER_AND_SERIAL_OPTIONS_VIEW];
  wire six_clock_mode = clksel[`SPU_CLKSEL_SIX];
  wire tx_clock_source_select = clksel[`SPU_CLKSEL_TX];
  wire rx_clock_source_select = clksel[`SPU_CLKSEL_RX];
  wire spu_mode_type mode = spu_mode_type'({mode_select_hi, mode_select_lo}); // [R1]
  wire mode0 = mode == SPU_MODE_SHIFT;
  wire nine = mode[1];

  // Sixteen ticks make one bit outside shift mode.
  wire [1:0] fix_sh = {1'b0, baud_doubler} + {1'b0, six_clock_mode};
  wire [2:0] fix_div = 3'(`SPU_FIX_DIV >> fix_sh);
  wire fix_tick = fix_cnt == 2'(fix_div - 3'd1); // [R3] [R16]
  wire t1_tick = timer1_ovf & (baud_doubler | t1_half); // [R16]
  wire tx_tick = mode == SPU_MODE_FIXED9 ? fix_tick :
                 (tx_clock_source_select ? timer2_ovf : t1_tick); // [R15]
  wire rx_tick = mode == SPU_MODE_FIXED9 ? fix_tick :
                 (rx_clock_source_select ? timer2_ovf : t1_tick); // [R14]
  wire [3:0] m0_last = six_clock_mode ? `SPU_M0_LAST_6 : `SPU_M0_LAST_12; // [R2]
  wire [3:0] m0_half = six_clock_mode ? `SPU_M0_HALF_6 : `SPU_M0_HALF_12;
  wire [3:0] bit_last = mode0 ? m0_last : `SPU_OVS_LAST;

  // Transmitter timing and sequencing.
  wire tx_adv = tx_state != SPU_IDLE && (mode0 | tx_tick);
  wire tx_bit_end = tx_adv && tx_phase == bit_last;
  wire tx_go = wr && hit_data && tx_state == SPU_IDLE;
  wire tx_last_data = tx_state == SPU_DATA && tx_cnt == 3'd7;
  wire ti_set = tx_bit_end && (mode0 ? tx_last_data :
                (tx_last_data && !tx_nine) || tx_state == SPU_NINTH); // [R12]
  always_comb begin
    next_tx_state = tx_state;
    if (tx_go) begin
      next_tx_state = mode0 ? SPU_DATA : SPU_START;
    end else if (tx_bit_end) begin
      case (tx_state)
        SPU_START: next_tx_state = SPU_DATA;
        SPU_DATA: begin
          if (tx_cnt == 3'd7) begin
            next_tx_state = mode0 ? SPU_IDLE : (tx_nine ? SPU_NINTH : SPU_STOP);
          end
        end
        SPU_NINTH: next_tx_state = SPU_STOP;
        default: next_tx_state = SPU_IDLE;
      endcase
    end
  end
  wire line_bit = tx_state == SPU_START ? 1'b0 :
                  tx_state == SPU_DATA ? tx_shift[0] :
                  tx_state == SPU_NINTH ? tx_ninth_hold : 1'b1; // [R10]

  // Receiver timing and sequencing.
  wire rx_adv = rx_state != SPU_IDLE && (mode0 | rx_tick);
  wire rx_bit_end = rx_adv && rx_phase == bit_last;
  wire rx_mid = rx_adv && rx_phase == `SPU_OVS_MID;
  wire rx_sample = mode0 ? rx_bit_end : rx_mid;
  wire rx_go = rx_enable && rx_state == SPU_IDLE &&
               (mode0 ? !rx_done_flag : (rxd_prev && !rxd_in)); // [R9]
  wire rx_eval = !mode0 && rx_state == SPU_STOP && rx_mid;
  wire m0_done = mode0 && rx_state == SPU_DATA && rx_sample && rx_cnt == 4'd7;
  wire [7:0] bcast = addr | admask;
  wire addr_hit = ((rx_shift ^ addr) & admask) == 8'h00 ||
                  ((rx_shift ^ bcast) & bcast) == 8'h00;
  // Filtering must stay off in shift mode, so it is not looked at there. [R8]
  wire rx_accept = !rx_done_flag && (mode == SPU_MODE_UART8 ?
                   (!address_filter_enable || rxd_in) : // [R7]
                   (!address_filter_enable || (rx_nine && addr_hit))); // [R6]
  wire ri_set = m0_done || (rx_eval && rx_accept); // [R13]
  wire fe_set = rx_eval && !rxd_in; // [R5]
  always_comb begin
    next_rx_state = rx_state;
    if (!rx_enable) begin
      next_rx_state = SPU_IDLE; // [R9]
    end else if (rx_go) begin
      next_rx_state = mode0 ? SPU_DATA : SPU_START;
    end else begin
      case (rx_state)
        SPU_START: begin
          if (rx_mid && rxd_in) begin
            next_rx_state = SPU_IDLE;
          end else if (rx_bit_end) begin
            next_rx_state = SPU_DATA;
          end
        end
        SPU_DATA: begin
          if (m0_done) begin
            next_rx_state = SPU_IDLE;
          end else if (rx_bit_end && rx_cnt == 4'd8) begin
            next_rx_state = nine ? SPU_NINTH : SPU_STOP;
          end
        end
        SPU_NINTH: next_rx_state = rx_bit_end ? SPU_STOP : SPU_NINTH;
        SPU_STOP: next_rx_state = rx_mid ? SPU_IDLE : SPU_STOP;
        default: next_rx_state = SPU_IDLE;
      endcase
    end
  end

  // Register read view; bit 7 of control follows the view select.
  wire bit7 = framing_view_select ? framing_error_flag : mode_select_hi; // [R4]
  wire [7:0] serial_port_control_rd = {bit7, mode_select_lo, address_filter_enable, rx_enable,
                        tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
  wire [7:0] rd = hit_power_and_serial_options ? power_and_serial_options : hit_serial_port_control ? serial_port_control_rd : hit_data ? rx_buf :
                  hit_addr ? addr : hit_admask ? admask : hit_clksel ? clksel :
                  hit_st ? irq_st : hit_mask ? irq_mask : 8'h00;
  wire [2:0] ev = {fe_set, ti_set, ri_set};
  wire [7:0] st_clr = (wr && hit_st) ? wd : 8'h00;
  // Hardware sets win over a software write in the same cycle.
  wire next_ti = ti_set | (wr_serial_port_control ? wd[`SPU_SERIAL_PORT_CONTROL_TI] : tx_done_flag); // [R12]
  wire next_ri = ri_set | (wr_serial_port_control ? wd[`SPU_SERIAL_PORT_CONTROL_RI] : rx_done_flag); // [R13]
  wire next_fe = fe_set | ((wr_serial_port_control && framing_view_select) ?
                 wd[`SPU_SERIAL_PORT_CONTROL_SM0] : framing_error_flag); // [R4] [R5]
  wire rb8_load = ri_set && !mode0;
  wire next_rb8 = rb8_load ? (mode == SPU_MODE_UART8 ? rxd_in : rx_nine) :
                  (wr_serial_port_control ? wd[`SPU_SERIAL_PORT_CONTROL_RB8] : rx_ninth_bit); // [R11]

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= acc;
      wb_rsp.dat <= acc ? {24'h0, rd} : 32'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      power_and_serial_options <= `SPU_POWER_AND_SERIAL_OPTIONS_RST;
      clksel <= `SPU_CLKSEL_RST;
      addr <= 8'h00;
      admask <= 8'h00;
      irq_mask <= 8'h00;
      {mode_select_hi, mode_select_lo, address_filter_enable, rx_enable,
       tx_ninth_bit} <= 5'(`SPU_SERIAL_PORT_CONTROL_RST >> 3);
    end else begin
      if (wr && hit_power_and_serial_options) power_and_serial_options <= wd;
      if (wr && hit_clksel) clksel <= wd;
      if (wr && hit_addr) addr <= wd;
      if (wr && hit_admask) admask <= wd;
      if (wr && hit_mask) irq_mask <= wd;
      if (wr_serial_port_control) begin
        if (!framing_view_select) mode_select_hi <= wd[`SPU_SERIAL_PORT_CONTROL_SM0]; // [R4]
        mode_select_lo <= wd[`SPU_SERIAL_PORT_CONTROL_SM1];
        address_filter_enable <= wd[`SPU_SERIAL_PORT_CONTROL_SM2];
        rx_enable <= wd[`SPU_SERIAL_PORT_CONTROL_REN];
        tx_ninth_bit <= wd[`SPU_SERIAL_PORT_CONTROL_TB8];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      rx_ninth_bit <= 1'b0;
      irq_st <= 8'h00;
      irq <= 1'b0;
      fix_cnt <= 2'd0;
      t1_half <= 1'b0;
      rxd_prev <= 1'b1;
    end else begin
      tx_done_flag <= next_ti;
      rx_done_flag <= next_ri;
      framing_error_flag <= next_fe;
      rx_ninth_bit <= next_rb8;
      irq_st <= {5'h00, ev | (irq_st[2:0] & ~st_clr[2:0])};
      irq <= |({5'h00, ev | (irq_st[2:0] & ~st_clr[2:0])} & irq_mask);
      fix_cnt <= fix_tick ? 2'd0 : fix_cnt + 2'd1;
      if (timer1_ovf) t1_half <= ~t1_half;
      rxd_prev <= rxd_in;
    end
  end

  // Transmit datapath; in shift mode the data leaves on the receive pin.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_state <= SPU_IDLE;
      tx_phase <= 4'd0;
      tx_cnt <= 3'd0;
      tx_shift <= 8'h00;
      tx_nine <= 1'b0;
      tx_ninth_hold <= 1'b0;
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      if (tx_go) begin
        tx_phase <= 4'd0;
        tx_cnt <= 3'd0;
        tx_shift <= wd;
        tx_nine <= nine;
        // Latched so a control write during the frame cannot change the ninth bit.
        tx_ninth_hold <= tx_ninth_bit; // [R10]
      end else if (tx_adv) begin
        tx_phase <= tx_bit_end ? 4'd0 : tx_phase + 4'd1;
        if (tx_bit_end && tx_state == SPU_DATA) begin
          tx_shift <= {1'b1, tx_shift[7:1]};
          tx_cnt <= tx_cnt + 3'd1;
        end
      end
      rxd_oe <= mode0 && next_tx_state != SPU_IDLE;
      rxd_out <= mode0 ? line_bit : 1'b1;
      if (!mode0) begin
        txd_out <= line_bit;
      end else if (tx_state != SPU_IDLE) begin
        txd_out <= tx_phase >= m0_half; // [R2]
      end else begin
        txd_out <= rx_state == SPU_IDLE || rx_phase >= m0_half;
      end
    end
  end

  // Receive datapath.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_state <= SPU_IDLE;
      rx_phase <= 4'd0;
      rx_cnt <= 4'd0;
      rx_shift <= 8'h00;
      rx_nine <= 1'b0;
      rx_buf <= 8'h00;
    end else begin
      rx_state <= next_rx_state;
      if (rx_go) begin
        rx_phase <= 4'd0;
        rx_cnt <= 4'd0;
      end else if (rx_adv) begin
        rx_phase <= rx_bit_end ? 4'd0 : rx_phase + 4'd1;
        if (rx_sample && rx_state == SPU_DATA) begin
          rx_shift <= {rxd_in, rx_shift[7:1]};
          rx_cnt <= rx_cnt + 4'd1;
        end
        if (rx_sample && rx_state == SPU_NINTH) rx_nine <= rxd_in; // [R11]
      end
      if (m0_done) rx_buf <= {rxd_in, rx_shift[7:1]};
      else if (ri_set) rx_buf <= rx_shift;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_fe_sets;
    rx_eval && !rxd_in |=> framing_error_flag ##1 framing_error_flag;
  endproperty
  a_fe_sets: assert property (p_fe_sets) else $error("framing error not held"); // [R5]
  property p_filter9;
    ri_set && nine && address_filter_enable |-> rx_nine && addr_hit;
  endproperty
  a_filter9: assert property (p_filter9) else $error("filtered 9-bit frame accepted"); // [R6]
  property p_filter8;
    ri_set && mode == SPU_MODE_UART8 && address_filter_enable |-> rxd_in;
  endproperty
  a_filter8: assert property (p_filter8) else $error("bad stop accepted"); // [R7]
  property p_no_rx_off;
    !rx_enable && rx_state == SPU_IDLE |=> rx_state == SPU_IDLE;
  endproperty
  a_no_rx_off: assert property (p_no_rx_off) else $error("receiver ran while off"); // [R9]
  property p_ninth_tx;
    tx_state == SPU_NINTH && !mode0 |=> txd_out == $past(tx_ninth_hold);
  endproperty
  a_ninth_tx: assert property (p_ninth_tx) else $error("ninth bit wrong on line"); // [R10]
  property p_rb8_stop;
    rb8_load && mode == SPU_MODE_UART8 |=> rx_ninth_bit == $past(rxd_in);
  endproperty
  a_rb8_stop: assert property (p_rb8_stop) else $error("stop bit not captured"); // [R11]
  property p_ti_stop;
    tx_state == SPU_DATA && next_tx_state == SPU_STOP |=> tx_done_flag && tx_state == SPU_STOP;
  endproperty
  a_ti_stop: assert property (p_ti_stop) else $error("transmit done late"); // [R12]
  property p_ri_mid;
    rx_eval && rx_accept |=> rx_done_flag && rx_state == SPU_IDLE;
  endproperty
  a_ri_mid: assert property (p_ri_mid) else $error("receive done missing"); // [R13]
  property p_fix_rate;
    fix_tick && fix_sh == 2'd0 && $past(fix_sh) == 2'd0 && $past(fix_sh, 2) == 2'd0 &&
      $past(fix_sh, 3) == 2'd0 && $past(fix_sh, 4) == 2'd0 && $past(nrst, 4)
      |-> $past(fix_tick, 4) && !$past(fix_tick) &&
      !$past(fix_tick, 2) && !$past(fix_tick, 3);
  endproperty
  a_fix_rate: assert property (p_fix_rate) else $error("fixed rate period wrong"); // [R3]
  property p_m0_rate;
    tx_bit_end && mode0 && !six_clock_mode && tx_state == SPU_DATA && tx_cnt != 3'd7
      |=> !tx_bit_end [*8] ##1 !tx_bit_end [*3] ##1 tx_bit_end;
  endproperty
  a_m0_rate: assert property (p_m0_rate) else $error("shift bit time wrong"); // [R2]

  c_tx_frame: cover property (ti_set && !mode0);
  c_rx_frame: cover property (ri_set && mode == SPU_MODE_VAR9);
  c_frame_err: cover property (fe_set);
  c_m0_rx: cover property (m0_done);
endmodule : spu_uart

// *** bench/spu_peer.sv ***
// Remote serial peer that drives frames onto the receive pin and decodes the transmit pin.
module spu_peer (
  // Clock
  input wire logic core_clk,
  // Frame to send and bit length in clocks; a zero length stops decoding
  input wire logic send,
  input wire logic [8:0] word,
  input wire logic nine,
  input wire logic stop_val,
  input wire logic [15:0] bit_clks,
  // Line
  output logic line,
  input wire logic txd,
  // Decoded frames and count of frames sent
  output logic [8:0] got,
  output logic got_stop,
  output logic [7:0] got_cnt,
  output logic [7:0] sent_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int k;
  int j;
  // A released line rests at the stop level, as a receiver expects between frames.
  initial begin
    line = 1'h1;
    sent_cnt = 8'h00;
    forever begin
      @(posedge core_clk);
      if (send) begin
        for (k = 0; k < (nine ? 11 : 10); k++) begin
          line <= (k == 0) ? 1'h0 : (k <= 8) ? word[k-1] : (nine && k == 9) ? word[8] : stop_val;
          repeat (bit_clks) @(posedge core_clk);
        end
        line <= 1'h1;
        sent_cnt = sent_cnt + 8'h01;
      end
    end
  end
  // Samples mid-bit, so a wrong bit length shows up as corrupt data.
  initial begin
    got = 9'h000;
    got_stop = 1'h0;
    got_cnt = 8'h00;
    forever begin
      @(posedge core_clk);
      if (txd === 1'h0 && bit_clks != 16'h0000) begin
        repeat (bit_clks / 2) @(posedge core_clk);
        got = 9'h000;
        for (j = 0; j < (nine ? 9 : 8); j++) begin
          repeat (bit_clks) @(posedge core_clk);
          got[j] = txd;
        end
        repeat (bit_clks) @(posedge core_clk);
        got_stop = txd;
        got_cnt = got_cnt + 8'h01;
      end
    end
  end
endmodule : spu_peer

// *** bench/serial_port_uart_test.sv ***
// Self-checking bench of the serial port: registers, frames both ways, interrupt.
`include "spu_params.svh"
module serial_port_uart_test import spu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic t1 = 1'h0;
  logic t2 = 1'h0;
  logic send = 1'h0;
  logic nine = 1'h0;
  logic stop_val = 1'h1;
  logic [1:0] tdiv = 2'h0;
  logic [8:0] word = 9'h000;
  logic [15:0] bit_clks = 16'h0000;
  spu_wb_req_type wb_req = '0;
  spu_wb_rsp_type wb_rsp;
  logic rxd_out, rxd_oe, txd_out, irq, peer_line, got_stop;
  logic [8:0] got;
  logic [7:0] got_cnt, sent_cnt;
  int bad_count = 0;
  int n_checks = 0;
  // The shared pin carries the port's shift data while it drives, else the peer.
  wire logic rxd_pin = rxd_oe ? rxd_out : peer_line;
  spu_uart spu_uart_inst (.core_clk(core_clk), .nrst(nrst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .timer1_ovf(t1), .timer2_ovf(t2), .rxd_in(rxd_pin), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd_out(txd_out), .irq(irq));
  spu_peer spu_peer_inst (.core_clk(core_clk), .send(send), .word(word), .nine(nine),
    .stop_val(stop_val), .bit_clks(bit_clks), .line(peer_line), .txd(txd_out), .got(got),
    .got_stop(got_stop), .got_cnt(got_cnt), .sent_cnt(sent_cnt));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Timer one pulses every second clock, timer two every fourth.
  always @(posedge core_clk) begin
    tdiv <= tdiv + 2'h1;
    t1 <= tdiv[0];
    t2 <= (tdiv == 2'h3);
  end
  task automatic end_sim();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic hang();
    bad_count++;
    $display("[ERR] wait expected done seen timeout");
    end_sim();
  endtask : hang
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                    output logic [7:0] rd);
    int i;
    wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: {22'h0, idx, 2'h0}, sel: 4'h1,
                dat: {24'h0, wd}};
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (wb_rsp.ack !== 1'h1 && i < 20);
    if (i >= 20) hang();
    rd = wb_rsp.dat[7:0];
    wb_req <= '0;
    @(posedge core_clk);
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    wb(1'h1, idx, d, x);
    // The interrupt line follows a mask register write one cycle late.
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    wb(1'h0, idx, 8'h00, d);
  endtask : rd
  task automatic wait_peer(input logic [7:0] c0, input logic sent);
    int i;
    i = 0;
    while ((sent ? sent_cnt : got_cnt) === c0 && i < 2000) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= 2000) hang();
  endtask : wait_peer
  task automatic wait_flag(input logic [7:0] idx, input int b);
    logic [7:0] v;
    int i;
    i = 0;
    do begin
      rd(idx, v);
      i++;
    end while (v[b] !== 1'h1 && i < 400);
    if (i >= 400) hang();
  endtask : wait_flag
  task automatic t_regs();
    logic [7:0] v;
    rd(`SPU_IDX_POWER_AND_SERIAL_OPTIONS, v);
    chk("options reset", v, 8'h10);
    rd(`SPU_IDX_SERIAL_PORT_CONTROL, v);
    chk("control reset", v, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, v);
    chk("unmapped read", v, 8'h00);
  endtask : t_regs
  task automatic t_tx(input logic [1:0] mode, input logic [7:0] power_and_serial_options, input logic [7:0] clk,
                      input logic [15:0] per, input logic tb8, input logic [7:0] d);
    logic [7:0] c0;
    wr(`SPU_IDX_POWER_AND_SERIAL_OPTIONS, power_and_serial_options);
    wr(`SPU_IDX_CLKSEL, clk);
    wr(`SPU_IDX_SERIAL_PORT_CONTROL, {mode, 2'h0, tb8, 3'h0});
    bit_clks <= per;
    nine <= mode[1];
    c0 = got_cnt;
    wr(`SPU_IDX_DATA, d);
    wait_flag(`SPU_IDX_SERIAL_PORT_CONTROL, `SPU_SERIAL_PORT_CONTROL_TI);
    chk("line at tx done", txd_out, 16'h1);
    chk("frames at tx done", got_cnt, c0);
    wait_peer(c0, 1'h0);
    chk("tx frame", got, {mode[1] & tb8, d});
    chk("tx stop", got_stop, 16'h1);
    // The stop bit still runs after the peer has sampled it; a data write then is dropped.
    repeat (per) @(posedge core_clk);
  endtask : t_tx
  task automatic t_rx(input logic [7:0] serial_port_control, input logic [7:0] clk, input logic [8:0] w,
                      input logic stopv, input logic [2:0] exp);
    logic [7:0] c0, v;
    wr(`SPU_IDX_POWER_AND_SERIAL_OPTIONS, 8'h00);
    wr(`SPU_IDX_CLKSEL, clk);
    wr(`SPU_IDX_SERIAL_PORT_CONTROL, serial_port_control);
    bit_clks <= 16'h0040;
    nine <= serial_port_control[7];
    word <= w;
    stop_val <= stopv;
    c0 = sent_cnt;
    send <= 1'h1;
    @(posedge core_clk);
    send <= 1'h0;
    wait_peer(c0, 1'h1);
    rd(`SPU_IDX_SERIAL_PORT_CONTROL, v);
    chk("mode view", v[7], serial_port_control[7]);
    chk("rx done", v[0], exp[2]);
    if (exp[2]) begin
      chk("rx ninth", v[2], exp[1]);
      rd(`SPU_IDX_DATA, v);
      chk("rx data", v, w[7:0]);
    end
    wr(`SPU_IDX_POWER_AND_SERIAL_OPTIONS, 8'h40);
    rd(`SPU_IDX_SERIAL_PORT_CONTROL, v);
    chk("framing", v[7], exp[0]);
    wr(`SPU_IDX_POWER_AND_SERIAL_OPTIONS, 8'h00);
    wr(`SPU_IDX_SERIAL_PORT_CONTROL, 8'h00);
  endtask : t_rx
  task automatic t_irq();
    logic [7:0] c0, v;
    wr(`SPU_IDX_IRQ_ST, 8'hff);
    wr(`SPU_IDX_IRQ_MASK, 8'h02);
    chk("irq idle", irq, 16'h0);
    wr(`SPU_IDX_SERIAL_PORT_CONTROL, 8'h80);
    c0 = got_cnt;
    wr(`SPU_IDX_DATA, 8'h11);
    wait_flag(`SPU_IDX_IRQ_ST, `SPU_IRQ_TX);
    @(posedge core_clk);
    chk("irq raised", irq, 16'h1);
    wr(`SPU_IDX_IRQ_MASK, 8'h00);
    chk("irq masked", irq, 16'h0);
    wr(`SPU_IDX_IRQ_MASK, 8'h02);
    chk("irq unmasked", irq, 16'h1);
    wr(`SPU_IDX_IRQ_ST, 8'h02);
    chk("irq cleared", irq, 16'h0);
    rd(`SPU_IDX_IRQ_ST, v);
    chk("status cleared", v[1], 16'h0);
    wait_peer(c0, 1'h0);
    repeat (64) @(posedge core_clk);
  endtask : t_irq
  task automatic t_shift(input logic [7:0] clk, input logic [15:0] per);
    logic [7:0] d;
    logic oe, prev;
    int gap, i, b;
    bit_clks <= 16'h0000;
    wr(`SPU_IDX_CLKSEL, clk);
    wr(`SPU_IDX_SERIAL_PORT_CONTROL, 8'h00);
    wr(`SPU_IDX_DATA, 8'hc3);
    prev = txd_out;
    oe = 1'h1;
    gap = 0;
    b = 0;
    i = 0;
    while (b < 8 && i < 400) begin
      @(posedge core_clk);
      i++;
      gap++;
      if (prev === 1'h0 && txd_out === 1'h1) begin
        d[b] = rxd_pin;
        oe = oe & rxd_oe;
        if (b > 0) chk("shift bit time", 16'(gap), per);
        gap = 0;
        b++;
      end
      prev = txd_out;
    end
    if (b < 8) hang();
    chk("shift data", d, 8'hc3);
    chk("shift drive", oe, 16'h1);
    wait_flag(`SPU_IDX_SERIAL_PORT_CONTROL, `SPU_SERIAL_PORT_CONTROL_TI);
  endtask : t_shift
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'h1;
    t_regs();
    t_tx(2'h2, 8'h00, 8'h00, 16'd64, 1'h1, 8'h96);
    t_tx(2'h2, 8'h80, 8'h00, 16'd32, 1'h0, 8'h69);
    t_tx(2'h2, 8'h00, 8'h01, 16'd32, 1'h1, 8'h01);
    t_tx(2'h2, 8'h80, 8'h01, 16'd16, 1'h1, 8'h80);
    t_tx(2'h3, 8'h00, 8'h00, 16'd64, 1'h1, 8'hc5);
    t_tx(2'h3, 8'h80, 8'h00, 16'd32, 1'h0, 8'h3c);
    t_tx(2'h1, 8'h00, 8'h10, 16'd64, 1'h0, 8'h5a);
    t_rx(8'h50, 8'h20, 9'h0a5, 1'h1, 3'h6);
    t_rx(8'h50, 8'h00, 9'h03c, 1'h0, 3'h5);
    t_rx(8'h70, 8'h00, 9'h0c3, 1'h0, 3'h1);
    t_rx(8'h50, 8'h00, 9'h011, 1'h1, 3'h7);
    wr(`SPU_IDX_POWER_AND_SERIAL_OPTIONS, 8'h40);
    wr(`SPU_IDX_SERIAL_PORT_CONTROL, 8'h00);
    wr(`SPU_IDX_ADDR, 8'h5a);
    wr(`SPU_IDX_ADMASK, 8'hff);
    t_rx(8'hf0, 8'h00, 9'h05a, 1'h1, 3'h0);
    t_rx(8'hf0, 8'h00, 9'h15a, 1'h1, 3'h6);
    t_rx(8'hf0, 8'h00, 9'h133, 1'h1, 3'h0);
    t_rx(8'h80, 8'h00, 9'h1ff, 1'h1, 3'h0);
    t_irq();
    t_shift(8'h00, 16'd12);
    t_shift(8'h01, 16'd6);
    end_sim();
  end
endmodule : serial_port_uart_test
